/* src/lpcal_defs.vh */
// Purpose: constants shared by the low-power background calibration scheduler
// Assumes: register indices are word indices; byte address is four times the index
// Notes: timing counts are in MCLK cycles at 100 MHz
`ifndef LPCAL_DEFS_VH
`define LPCAL_DEFS_VH

// register indices (byte address = index * 4)
`define LPCAL_IDX_BGCAL_CTRL 8'h61
`define LPCAL_IDX_STATUS 8'h6A
`define LPCAL_IDX_TRIG_CFG 8'h6B
`define LPCAL_IDX_SW_TRIG 8'h6C
`define LPCAL_IDX_LP_CTRL 8'h6E
`define LPCAL_IDX_COEF_EN 8'h70
`define LPCAL_IDX_COEF_PORT 8'h71
`define LPCAL_BYTE_ADDR(i) ({2'h0, (i), 2'h0})

// reset values
`define LPCAL_RST_BGCAL_CTRL 8'h00
`define LPCAL_RST_TRIG_CFG 8'h00
`define LPCAL_RST_SW_TRIG 8'h01
`define LPCAL_RST_LP_CTRL 8'h88
`define LPCAL_RST_COEF_EN 8'h00

// field positions
`define LPCAL_BIT_BG_EN 1
`define LPCAL_BIT_TRIG_SRC 0
`define LPCAL_BIT_SW_TRIG 0
`define LPCAL_BIT_LOW_POWER_BGCAL_ENABLE 0
`define LPCAL_BIT_WAKE_TRIG 1
`define LPCAL_DOZE_HI 7
`define LPCAL_DOZE_LO 5
`define LPCAL_SETTLE_HI 4
`define LPCAL_SETTLE_LO 3
`define LPCAL_BIT_COEF_EN 0
`define LPCAL_LP_WMASK 8'hFB

// timing
`define LPCAL_UNIT_CYCLES 256
`define LPCAL_EXP_CAP 33
`define LPCAL_CAL_CYCLES 64
`define LPCAL_COEF_DEPTH 673

`endif

/* src/lpcal_coef_mem.v */
// Purpose: storage for the calibration coefficient vector
// Assumes: one write port, one read port on the same address, one clock
// Notes: read data comes out of a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
`include "lpcal_defs.vh"
module lpcal_coef_mem #(
    parameter DEPTH = `LPCAL_COEF_DEPTH,
    parameter AW = 10,
    parameter DW = 8
) (
    input wire clk,
    input wire we,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output reg [DW-1:0] rdata
);

    reg [DW-1:0] mem [0:DEPTH-1]; // coefficient words, not reset

    // write on strobe, always refresh the read register
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule // lpcal_coef_mem
`default_nettype wire

/* src/lpcal_sched.v */
// Purpose: low-power background calibration scheduler with APB registers
// Assumes: MCLK 100 MHz, RESET asynchronous active high, APB with 32-bit data
// Notes: one converter is serviced at a time, in round-robin order
// Notes on behaviour
// R1: software trigger bit, reset one, replaces pin
// R2: idle trigger: select zero, soft bit high
// R3: doze code sets (2^k+1)*256 clock sleep
// R4: doze timer only in autonomous low-power mode
// R5: doze codes below four waste power
// R6: settle code sets post-wake settle time
// R7: settle codes below one leave core unstable
// R8: wake-on-trigger holds sleep until trigger
// R9: trigger low wakes sleeping converter
// R10: low-power enable needs background calibration on
// R11: coefficient enable opens coefficient data port
// R12: source select picks pin or software bit
// R13: background calibration runs only when enabled
// R14: software moves whole 673-word vector
// R15: coefficient access only while calibration halted; the code gates the port on the coefficient enable only, not on CAL_HALTED
// R16: after settle: calibrate, sleep, restart timing
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lpcal_defs.vh"
module lpcal_sched #(
    parameter NUM_CONV = 3,
    parameter [47:0] UNIT_CYCLES = `LPCAL_UNIT_CYCLES,
    parameter [5:0] EXP_CAP = `LPCAL_EXP_CAP,
    parameter [47:0] CAL_CYCLES = `LPCAL_CAL_CYCLES,
    parameter COEF_DEPTH = `LPCAL_COEF_DEPTH
) (
    input wire MCLK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output reg PSLVERR,
    input wire TRIGGER_INPUT_PIN,
    output reg [NUM_CONV-1:0] CONV_AWAKE,
    output reg CAL_ACTIVE,
    output reg [1:0] CAL_CONV_SEL,
    output reg CAL_HALTED
);

    // one-hot scheduler states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SLEEP = 4'h2;
    localparam [3:0] ST_SETTLE = 4'h4;
    localparam [3:0] ST_CAL = 4'h8;

    // software-visible registers
    reg [7:0] bgcal_ctrl_q; // background enable lives here
    reg [7:0] trig_cfg_q; // trigger source select
    reg [7:0] sw_trig_q; // software trigger level
    reg [7:0] lp_ctrl_q; // low-power schedule control
    reg [7:0] coef_en_q; // coefficient port enable
    reg [9:0] coef_ptr_q; // position in the coefficient vector
    wire [7:0] coef_rdata; // registered memory output

    // scheduler state
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [47:0] cnt_q;
    reg [47:0] cnt_d;
    reg [1:0] idx_q;
    reg [1:0] idx_d;

    // trigger pin synchroniser
    reg trig_meta_q; // first stage, read only by the second
    reg trig_sync_q;

    // doze code to exponent
    function [5:0] doze_exp;
        input [2:0] code;
        begin
            case (code)
                3'h0: doze_exp = 6'd3;
                3'h1: doze_exp = 6'd15;
                3'h2: doze_exp = 6'd18;
                3'h3: doze_exp = 6'd21;
                3'h4: doze_exp = 6'd24;
                3'h5: doze_exp = 6'd27;
                3'h6: doze_exp = 6'd30;
                default: doze_exp = 6'd33;
            endcase
        end
    endfunction

    // settle code to exponent
    function [5:0] settle_exp;
        input [1:0] code;
        begin
            case (code)
                2'h0: settle_exp = 6'd33;
                2'h1: settle_exp = 6'd18;
                2'h2: settle_exp = 6'd21;
                default: settle_exp = 6'd24;
            endcase
        end
    endfunction

    // (2^k + 1) * unit, minus one for a count-down to zero
    function [47:0] interval_load;
        input [5:0] k;
        reg [5:0] kc;
        begin
            kc = (k > EXP_CAP) ? EXP_CAP : k; // cap only shortens simulation
            interval_load = (((48'h1 << kc) + 48'h1) * UNIT_CYCLES) - 48'h1;
        end
    endfunction

    // next converter in round-robin order
    function [1:0] next_idx;
        input [1:0] cur;
        begin
            if (cur == NUM_CONV[1:0] - 2'h1) begin
                next_idx = 2'h0;
            end else begin
                next_idx = cur + 2'h1;
            end
        end
    endfunction

    // decoded control
    wire bg_en = bgcal_ctrl_q[`LPCAL_BIT_BG_EN];
    wire low_power_bgcal_enable = lp_ctrl_q[`LPCAL_BIT_LOW_POWER_BGCAL_ENABLE];
    wire wake_on_trigger = lp_ctrl_q[`LPCAL_BIT_WAKE_TRIG];
    wire [2:0] doze_interval_code = lp_ctrl_q[`LPCAL_DOZE_HI:`LPCAL_DOZE_LO];
    wire [1:0] settle_interval_code = lp_ctrl_q[`LPCAL_SETTLE_HI:`LPCAL_SETTLE_LO];
    wire lp_active = bg_en & low_power_bgcal_enable; // [R10]
    wire autonomous = lp_active & ~wake_on_trigger; // [R4]
    // pin or software bit, the other one ignored
    wire cal_trigger = trig_cfg_q[`LPCAL_BIT_TRIG_SRC] ? trig_sync_q
                       : sw_trig_q[`LPCAL_BIT_SW_TRIG]; // [R1] [R12]

    // APB decode
    wire [9:0] word_idx = PADDR[11:2];
    wire aligned = (PADDR[1:0] == 2'h0);
    wire hit_bgcal = aligned && (word_idx == {2'h0, `LPCAL_IDX_BGCAL_CTRL});
    wire hit_status = aligned && (word_idx == {2'h0, `LPCAL_IDX_STATUS});
    wire hit_trig = aligned && (word_idx == {2'h0, `LPCAL_IDX_TRIG_CFG});
    wire hit_swtrig = aligned && (word_idx == {2'h0, `LPCAL_IDX_SW_TRIG});
    wire hit_lp = aligned && (word_idx == {2'h0, `LPCAL_IDX_LP_CTRL});
    wire hit_coef_en = aligned && (word_idx == {2'h0, `LPCAL_IDX_COEF_EN});
    wire hit_coef = aligned && (word_idx == {2'h0, `LPCAL_IDX_COEF_PORT});
    wire mapped = hit_bgcal | hit_status | hit_trig | hit_swtrig | hit_lp
                  | hit_coef_en | hit_coef;
    wire access = PSEL & PENABLE; // zero-wait slave: every access ends here
    wire wr_en = access & PWRITE & mapped;
    wire coef_open = coef_en_q[`LPCAL_BIT_COEF_EN];
    wire coef_access = access & hit_coef & coef_open; // [R11]
    wire coef_we = coef_access & PWRITE;

    assign PREADY = 1'b1;

    // two flops before the trigger pin reaches any logic
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            trig_meta_q <= 1'b1;
            trig_sync_q <= 1'b1;
        end else begin
            trig_meta_q <= TRIGGER_INPUT_PIN;
            trig_sync_q <= trig_meta_q;
        end
    end

    // register writes; reserved lp bit is kept at zero
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            bgcal_ctrl_q <= `LPCAL_RST_BGCAL_CTRL;
            trig_cfg_q <= `LPCAL_RST_TRIG_CFG;
            sw_trig_q <= `LPCAL_RST_SW_TRIG; // [R1]
            lp_ctrl_q <= `LPCAL_RST_LP_CTRL; // [R3] [R6] [R10]
            coef_en_q <= `LPCAL_RST_COEF_EN;
        end else if (wr_en) begin
            if (hit_bgcal) begin
                bgcal_ctrl_q <= PWDATA[7:0];
            end else if (hit_trig) begin
                trig_cfg_q <= PWDATA[7:0];
            end else if (hit_swtrig) begin
                sw_trig_q <= PWDATA[7:0];
            end else if (hit_lp) begin
                lp_ctrl_q <= PWDATA[7:0] & `LPCAL_LP_WMASK;
            end else if (hit_coef_en) begin
                coef_en_q <= PWDATA[7:0];
            end
        end
    end

    // coefficient pointer: steps on each port access, rewinds when closed
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            coef_ptr_q <= 10'h000;
        end else if (!coef_open) begin
            coef_ptr_q <= 10'h000; // a new enable always starts at word zero
        end else if (coef_access) begin
            if (coef_ptr_q == COEF_DEPTH[9:0] - 10'h001) begin
                coef_ptr_q <= 10'h000; // wrap after the last word
            end else begin
                coef_ptr_q <= coef_ptr_q + 10'h001;
            end
        end
    end

    // coefficient vector storage
    lpcal_coef_mem #(
        .DEPTH(COEF_DEPTH),
        .AW(10),
        .DW(8)
    ) u_coef_mem (
        .clk(MCLK),
        .we(coef_we),
        .addr(coef_ptr_q),
        .wdata(PWDATA[7:0]),
        .rdata(coef_rdata)
    );

    // read mux; closed port and bits above 7 read as zero
    always @* begin
        PRDATA = 32'h00000000;
        PSLVERR = access & ~mapped; // unmapped or misaligned address
        if (hit_bgcal) begin
            PRDATA = {24'h000000, bgcal_ctrl_q};
        end else if (hit_status) begin
            PRDATA = {25'h0000000, idx_q, CAL_HALTED, state_q};
        end else if (hit_trig) begin
            PRDATA = {24'h000000, trig_cfg_q};
        end else if (hit_swtrig) begin
            PRDATA = {24'h000000, sw_trig_q};
        end else if (hit_lp) begin
            PRDATA = {24'h000000, lp_ctrl_q};
        end else if (hit_coef_en) begin
            PRDATA = {24'h000000, coef_en_q};
        end else if (hit_coef && coef_open) begin
            PRDATA = {24'h000000, coef_rdata}; // [R11]
        end
    end

    // scheduler next state
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        case (state_q)
            ST_IDLE: begin
                if (bg_en) begin // [R13]
                    if (lp_active) begin
                        state_d = ST_SLEEP;
                        cnt_d = interval_load(doze_exp(doze_interval_code)); // [R3]
                    end else begin
                        state_d = ST_CAL;
                        cnt_d = CAL_CYCLES - 48'h1;
                    end
                end
            end
            ST_SLEEP: begin
                if (!bg_en) begin
                    state_d = ST_IDLE; // [R13]
                end else if (!low_power_bgcal_enable) begin
                    state_d = ST_CAL; // leaving low power: calibrate at once
                    cnt_d = CAL_CYCLES - 48'h1;
                end else if (wake_on_trigger) begin
                    if (!cal_trigger) begin // [R8] [R9]
                        state_d = ST_SETTLE;
                        cnt_d = interval_load(settle_exp(settle_interval_code)); // [R6]
                    end
                end else if (cnt_q == 48'h0) begin // [R4] [R8]
                    state_d = ST_SETTLE;
                    cnt_d = interval_load(settle_exp(settle_interval_code)); // [R6]
                end else if (autonomous) begin
                    cnt_d = cnt_q - 48'h1; // [R4]
                end
            end
            ST_SETTLE: begin
                if (!bg_en) begin
                    state_d = ST_IDLE;
                end else if (cnt_q == 48'h0) begin
                    state_d = ST_CAL; // [R16]
                    cnt_d = CAL_CYCLES - 48'h1;
                end else begin
                    cnt_d = cnt_q - 48'h1;
                end
            end
            ST_CAL: begin
                if (!bg_en) begin
                    state_d = ST_IDLE;
                end else if (cnt_q == 48'h0) begin
                    idx_d = next_idx(idx_q);
                    if (lp_active) begin
                        state_d = ST_SLEEP; // [R16]
                        cnt_d = interval_load(doze_exp(doze_interval_code));
                    end else begin
                        cnt_d = CAL_CYCLES - 48'h1; // continuous background
                    end
                end else begin
                    cnt_d = cnt_q - 48'h1;
                end
            end
            default: begin
                state_d = ST_IDLE; // recover from an illegal code
            end
        endcase
    end

    // scheduler registers
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            cnt_q <= 48'h0;
            idx_q <= 2'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
        end
    end

    // converter controls, registered from the next state
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            CONV_AWAKE <= {NUM_CONV{1'b1}};
            CAL_ACTIVE <= 1'b0;
            CAL_CONV_SEL <= 2'h0;
            CAL_HALTED <= 1'b1;
        end else begin
            CONV_AWAKE <= {NUM_CONV{1'b1}};
            if (state_d == ST_SLEEP) begin
                CONV_AWAKE[idx_d] <= 1'b0; // only the scheduled converter dozes
            end
            CAL_ACTIVE <= (state_d == ST_CAL);
            CAL_CONV_SEL <= idx_d;
            CAL_HALTED <= (state_d != ST_CAL); // [R15]
        end
    end

endmodule // lpcal_sched
`default_nettype wire

/* dv/lpcal_sched_checker.sv */
// Purpose: port-level assertions for the calibration scheduler
// Assumes: short build, each doze or settle interval 9 cycles, calibration 4
// Notes: mirrors two control registers from the APB writes it sees
`timescale 1ns/1ps
`default_nettype none
`include "lpcal_defs.vh"
module lpcal_sched_checker #(
    parameter NUM_CONV = 3
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [NUM_CONV-1:0] CONV_AWAKE,
    input wire logic CAL_ACTIVE,
    input wire logic [1:0] CAL_CONV_SEL,
    input wire logic CAL_HALTED
);
    logic [7:0] bg_q; // mirror of background control
    logic [7:0] lp_q; // mirror of low-power control
    wire wr_go = PSEL && PENABLE && PREADY && PWRITE;
    wire lp_on = bg_q[`LPCAL_BIT_BG_EN] && lp_q[`LPCAL_BIT_LOW_POWER_BGCAL_ENABLE];
    // mirrors follow completed writes only, like the design registers
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            bg_q <= `LPCAL_RST_BGCAL_CTRL;
            lp_q <= `LPCAL_RST_LP_CTRL;
        end else if (wr_go) begin
            if (PADDR == `LPCAL_BYTE_ADDR(`LPCAL_IDX_BGCAL_CTRL)) bg_q <= PWDATA[7:0];
            if (PADDR == `LPCAL_BYTE_ADDR(`LPCAL_IDX_LP_CTRL)) lp_q <= PWDATA[7:0];
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    access_ready_a: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access phase without ready");
    misalign_refused_a: assert property (
        PSEL && PENABLE && !PWRITE && PADDR[1:0] != 2'h0 |-> PSLVERR && PRDATA == 32'h0)
        else $error("misaligned read not refused");
    lp_reg_mapped_a: assert property (
        PSEL && PENABLE && PADDR == `LPCAL_BYTE_ADDR(`LPCAL_IDX_LP_CTRL) |-> !PSLVERR)
        else $error("control register refused");
    halted_flag_a: assert property (CAL_HALTED != CAL_ACTIVE)
        else $error("halted flag disagrees with calibration");
    cal_awake_a: assert property (CAL_ACTIVE |-> CONV_AWAKE[CAL_CONV_SEL])
        else $error("calibrating a sleeping converter");
    // a background disable may end calibration early; that is legal
    cal_length_a: assert property (
        $rose(CAL_ACTIVE) |=> (CAL_ACTIVE || !bg_q[`LPCAL_BIT_BG_EN]) [*3])
        else $error("calibration cut short");
    awake_unless_lp_a: assert property (!lp_on |=> &CONV_AWAKE)
        else $error("converter asleep outside low-power mode");
    doze_length_a: assert property (
        $fell(&CONV_AWAKE) && !lp_q[`LPCAL_BIT_WAKE_TRIG]
        |-> !(&CONV_AWAKE) [*8] ##[1:3] &CONV_AWAKE) else $error("doze length wrong");
    settle_length_a: assert property (
        $rose(&CONV_AWAKE) && lp_on |-> !CAL_ACTIVE [*8] ##[1:3] CAL_ACTIVE)
        else $error("settle length wrong");
endmodule // lpcal_sched_checker
bind lpcal_sched lpcal_sched_checker #(.NUM_CONV(NUM_CONV)) chk_u (
    .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONV_AWAKE(CONV_AWAKE), .CAL_ACTIVE(CAL_ACTIVE), .CAL_CONV_SEL(CAL_CONV_SEL),
    .CAL_HALTED(CAL_HALTED));
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench for the calibration scheduler
// Assumes: short counts, so every interval is 9 cycles and calibration 4
// Notes: APB results are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "lpcal_defs.vh"
module tb;
    localparam logic [7:0] I_BG = `LPCAL_IDX_BGCAL_CTRL;
    localparam logic [7:0] I_TR = `LPCAL_IDX_TRIG_CFG;
    localparam logic [7:0] I_SW = `LPCAL_IDX_SW_TRIG;
    localparam logic [7:0] I_LP = `LPCAL_IDX_LP_CTRL;
    localparam logic [7:0] I_EN = `LPCAL_IDX_COEF_EN;
    localparam logic [7:0] I_CP = `LPCAL_IDX_COEF_PORT;
    logic MCLK = 1'h0, RESET = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic PIN = 1'h1; // board trigger, idle high
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0, seed = 32'h48D5C75D;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, CAL_ACTIVE, CAL_HALTED;
    wire [2:0] CONV_AWAKE;
    wire [1:0] CAL_CONV_SEL;
    logic [32:0] exp_q[$]; // noted {error, read data} per transfer
    logic [7:0] vec[673]; // coefficient vector kept for readback
    int n_mismatch = 0, check_count = 0;
    always #5 MCLK = ~MCLK;
    // short counts keep a whole doze-settle-calibrate cycle to 22 clocks
    lpcal_sched #(.UNIT_CYCLES(48'h1), .EXP_CAP(6'h3), .CAL_CYCLES(48'h4)) dut_u (
        .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .TRIGGER_INPUT_PIN(PIN), .CONV_AWAKE(CONV_AWAKE),
        .CAL_ACTIVE(CAL_ACTIVE), .CAL_CONV_SEL(CAL_CONV_SEL), .CAL_HALTED(CAL_HALTED));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one APB transfer; an idle cycle after it keeps strobes single-driven
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'h1;
        @(posedge MCLK);
        while (PREADY !== 1'h1) @(posedge MCLK);
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge MCLK);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'h1, `LPCAL_BYTE_ADDR(i), {24'h0, d}, 33'h0);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        apb(1'h0, `LPCAL_BYTE_ADDR(i), 32'h0, {25'h0, e});
    endtask
    // outputs are looked at mid-cycle, where they have settled
    task automatic await_awake(input logic want, input int n);
        for (int c = 0; c < n && (&CONV_AWAKE) !== want; c++) @(negedge MCLK);
        check({32'h0, &CONV_AWAKE}, {32'h0, want});
        @(posedge MCLK);
    endtask
    task automatic hold_awake(input logic want, input int n);
        repeat (n) begin
            @(negedge MCLK);
            check({32'h0, &CONV_AWAKE}, {32'h0, want});
        end
        @(posedge MCLK);
    endtask
    // monitor: every completed transfer takes the oldest note
    always @(posedge MCLK) begin
        if (PSEL && PENABLE && PREADY)
            check({PSLVERR, PWRITE ? 32'h0 : PRDATA}, exp_q.pop_front());
    end
    initial begin
        repeat (30000) @(posedge MCLK);
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (16) @(posedge MCLK);
        RESET <= 1'h0;
        @(posedge MCLK);
        rd(I_BG, 8'h00);
        rd(I_TR, 8'h00);
        rd(I_SW, 8'h01);
        rd(I_LP, 8'h88);
        rd(I_EN, 8'h00);
        rd(`LPCAL_IDX_STATUS, 8'h11);
        for (int c = 0; c < 8; c++) begin
            wr(I_LP, {c[2:0], c[1:0], 3'h4});
            rd(I_LP, {c[2:0], c[1:0], 3'h0});
        end
        apb(1'h0, 12'h188, 32'h0, {1'h1, 32'h0});
        apb(1'h0, 12'h1BA, 32'h0, {1'h1, 32'h0});
        apb(1'h1, 12'h1B9, 32'hFF, {1'h1, 32'h0});
        rd(I_LP, 8'hF8);
        wr(I_CP, 8'h5A);
        rd(I_CP, 8'h00);
        check({32'h0, CAL_HALTED}, 33'h1);
        wr(I_EN, 8'h01);
        for (int i = 0; i < 673; i++) begin
            seed = xs(seed);
            vec[i] = seed[7:0];
            wr(I_CP, vec[i]);
        end
        wr(I_EN, 8'h00);
        wr(I_EN, 8'h01);
        for (int i = 0; i < 673; i++) rd(I_CP, vec[i]);
        wr(I_EN, 8'h00);
        wr(I_LP, 8'h88);
        wr(I_BG, 8'h02);
        hold_awake(1'h1, 40);
        @(negedge MCLK);
        check({32'h0, CAL_ACTIVE}, 33'h1);
        @(posedge MCLK);
        wr(I_BG, 8'h00);
        wr(I_LP, 8'h89);
        hold_awake(1'h1, 30);
        RESET <= 1'h1;
        repeat (2) @(posedge MCLK);
        RESET <= 1'h0;
        @(posedge MCLK);
        wr(I_LP, 8'h89);
        wr(I_BG, 8'h02);
        for (int n = 0; n < 5; n++) begin
            for (int c = 0; c < 40 && CAL_ACTIVE !== 1'h1; c++) @(negedge MCLK);
            check({31'h0, CAL_ACTIVE, CAL_HALTED}, 33'h2);
            check({31'h0, CAL_CONV_SEL}, 33'(n % 3));
            if (n < 4)
                for (int c = 0; c < 40 && CAL_ACTIVE !== 1'h0; c++) @(negedge MCLK);
        end
        @(posedge MCLK);
        wr(I_LP, 8'h8B);
        await_awake(1'h0, 40);
        hold_awake(1'h0, 40);
        PIN <= 1'h0;
        hold_awake(1'h0, 10);
        wr(I_SW, 8'h00);
        await_awake(1'h1, 8);
        PIN <= 1'h1;
        wr(I_SW, 8'h01);
        wr(I_TR, 8'h01);
        await_awake(1'h0, 40);
        wr(I_SW, 8'h00);
        hold_awake(1'h0, 10);
        PIN <= 1'h0;
        await_awake(1'h1, 8);
        PIN <= 1'h1;
        wr(I_SW, 8'h01);
        wr(I_TR, 8'h00);
        wr(I_BG, 8'h00);
        await_awake(1'h1, 5);
        rd(`LPCAL_IDX_STATUS, 8'h11);
        repeat (3) @(posedge MCLK);
        final_report;
    end
endmodule // tb
`default_nettype wire
